// ===== hdl/smssc_core.sv
// Function
// - master drives data out, msb first
// - master data out is shift msb
// - slave data out floats when off/unselected
// - 3-wire slave always drives shift msb
// - clock only as master; deselected edges ignored
// - mode 00: 3-wire, slave always selected
// - mode 01: select input, low selects
// - mode 01 master: select low disables master
// - mode 1x: select output equals low bit
// - select pin routed unless mode 00
// - master enable; data write loads buffer
// - empty shifter loads buffer, starts clocking
// - done flag set at transfer end
// - received bits shift in, go to buffer
// - mode fault clears enables, sets flag
// - reset select mode is multi-master
// - slave sets done after eight bits
// - polarity sets idle level, phase edge
// - write to full buffer sets collision
module smssc_core (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic sck_link,
  input wire logic ctrl_wr,
  input wire logic ctrl_master_en,
  input wire logic ctrl_port_en,
  input wire logic [1:0] ctrl_mode,
  input wire logic clock_polarity_bit,
  input wire logic clock_phase_bit,
  input wire logic data_wr,
  input wire logic [7:0] data_wdata,
  input wire logic data_rd,
  input wire logic done_clr,
  input wire logic write_collision_flag_clr,
  input wire logic mode_fault_flag_clr,
  output logic [7:0] data_rdata,
  output logic master_enable_bit,
  output logic port_enable_bit,
  output logic [1:0] select_mode_field,
  output logic transfer_done_flag,
  output logic write_collision_flag,
  output logic mode_fault_flag,
  output logic rx_empty,
  output logic busy,
  output logic select_routed,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe,
  output logic sck_o,
  output logic sck_oe,
  input wire logic nss_i,
  output logic nss_o,
  output logic nss_oe
);
  import smssc_pkg::*;

  smssc_mst_t st_r;
  logic master_en_r;
  logic port_en_r;
  logic [1:0] mode_r;
  logic done_r;
  logic write_collision_flag_r;
  logic mode_fault_flag_r;
  logic rx_empty_r;
  logic [7:0] txb_r;
  logic txfull_r;
  logic [7:0] rxb_r;
  logic [7:0] sh_r;
  logic samp_r;
  logic [4:0] edge_r;
  logic [3:0] div_r;
  logic sck_r;
  logic done_d_r;
  logic ack_d_r;
  logic [SYNC_W-1:0] sync_q;
  logic miso_s;
  logic nss_s;
  logic master_on;
  logic slave_on;
  logic selected;
  logic fault;
  logic load_m;
  logic tick;
  logic sample_edge;
  logic shift_edge;
  logic end_shift;
  logic m_done;
  logic s_done;
  logic s_ack;
  logic lnk_clr;
  logic lnk_miso;
  logic [7:0] lnk_rx;
  logic lnk_done_tgl;
  logic lnk_ack_tgl;
  logic [7:0] m_rx_nxt;

  // miso, select and link-domain toggles pass two flops before use; lnk_clr takes the raw select
  smssc_sync #(
    .W(SYNC_W)
  ) u_sync (
    .core_clk(core_clk),
    .nrst(nrst),
    .d({miso_i, ~nss_i, lnk_done_tgl, lnk_ack_tgl}),
    .q(sync_q)
  );

  assign miso_s = sync_q[SYNC_MISO];
  // select travels inverted so the cleared flops mean deselected after reset
  assign nss_s = ~sync_q[SYNC_SEL];

  smssc_link u_link (
    .sck_link(sck_link),
    .nrst(nrst),
    .lnk_clr(lnk_clr),
    .edge_inv(clock_polarity_bit ^ clock_phase_bit),
    .mosi_i(mosi_i),
    .tx_byte(txb_r),
    .miso_bit(lnk_miso),
    .rx_byte(lnk_rx),
    .done_tgl(lnk_done_tgl),
    .ack_tgl(lnk_ack_tgl)
  );

  assign master_on = port_en_r & master_en_r;
  assign slave_on = port_en_r & ~master_en_r;
  // only mode 01 uses the select input; 00 and 1x leave the slave selected
  assign selected = (mode_r != MODE_4W_IN) | ~nss_s;
  assign fault = master_on & (mode_r == MODE_4W_IN) & ~nss_s;
  // raw select clears the link logic; a sync here would need sck edges
  assign lnk_clr = ~slave_on | ((mode_r == MODE_4W_IN) & nss_i);
  assign s_done = sync_q[SYNC_DONE] ^ done_d_r;
  assign s_ack = sync_q[SYNC_ACK] ^ ack_d_r;

  assign load_m = (st_r == SMSSC_IDLE) & master_on & txfull_r;
  assign tick = (st_r == SMSSC_RUN) & (div_r == HALF_LAST);
  // sample a cycle after the latching edge: the miso sync lags two cycles
  assign sample_edge = (st_r == SMSSC_RUN) & (div_r == 4'h0) & (edge_r[0] != clock_phase_bit)
                       & (edge_r != 5'h00);
  assign shift_edge = tick & (edge_r[0] != clock_phase_bit) & (edge_r != 5'h00);
  // with phase 1 the last sample lands on the final edge, so shift once more
  assign end_shift = (st_r == SMSSC_END) & clock_phase_bit;
  assign m_done = (st_r == SMSSC_END);
  assign m_rx_nxt = clock_phase_bit ? {sh_r[6:0], miso_s} : sh_r;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      done_d_r <= 1'b0;
      ack_d_r <= 1'b0;
    end else begin
      done_d_r <= sync_q[SYNC_DONE];
      ack_d_r <= sync_q[SYNC_ACK];
    end
  end

  // enables and select mode; a fault overrides a same-cycle write
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      master_en_r <= 1'b0;
      port_en_r <= 1'b0;
      mode_r <= MODE_RST;
    end else begin
      if (ctrl_wr) begin
        master_en_r <= ctrl_master_en;
        port_en_r <= ctrl_port_en;
        mode_r <= ctrl_mode;
      end
      if (fault) begin
        master_en_r <= 1'b0;
        port_en_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      mode_fault_flag_r <= 1'b0;
    end else if (fault) begin
      mode_fault_flag_r <= 1'b1;
    end else if (mode_fault_flag_clr) begin
      mode_fault_flag_r <= 1'b0;
    end
  end

  // transmit buffer: one byte shared by master and slave paths
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      txb_r <= BYTE_RST;
      txfull_r <= 1'b0;
    end else begin
      if (load_m || (slave_on && s_ack)) begin
        txfull_r <= 1'b0;
      end
      if (data_wr && !txfull_r) begin
        txb_r <= data_wdata;
        txfull_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      write_collision_flag_r <= 1'b0;
    end else if (data_wr && txfull_r) begin
      write_collision_flag_r <= 1'b1;
    end else if (write_collision_flag_clr) begin
      write_collision_flag_r <= 1'b0;
    end
  end

  // master sequencer: sixteen half periods per byte, then one end cycle
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      st_r <= SMSSC_IDLE;
      div_r <= 4'h0;
      edge_r <= 5'h00;
    end else begin
      case (st_r)
        SMSSC_IDLE: begin
          div_r <= 4'h0;
          edge_r <= 5'h00;
          if (load_m) begin
            st_r <= SMSSC_RUN;
          end
        end
        SMSSC_RUN: begin
          if (!master_on) begin
            st_r <= SMSSC_IDLE;
          end else if (tick) begin
            div_r <= 4'h0;
            edge_r <= edge_r + 5'h01;
            if (edge_r == EDGE_LAST) begin
              st_r <= SMSSC_END;
            end
          end else begin
            div_r <= div_r + 4'h1;
          end
        end
        SMSSC_END: begin
          st_r <= SMSSC_IDLE;
        end
        default: begin
          st_r <= SMSSC_IDLE;
        end
      endcase
    end
  end

  // serial clock toggles on each tick and rests at the polarity level
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      sck_r <= 1'b0;
    end else if (st_r == SMSSC_RUN && master_on) begin
      if (tick) begin
        sck_r <= ~sck_r;
      end
    end else begin
      sck_r <= clock_polarity_bit;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      samp_r <= 1'b0;
    end else if (sample_edge) begin
      samp_r <= miso_s;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      sh_r <= BYTE_RST;
    end else if (load_m) begin
      sh_r <= txb_r;
    end else if (shift_edge || end_shift) begin
      sh_r <= {sh_r[6:0], end_shift ? miso_s : samp_r};
    end
  end

  // receive buffer takes the master byte or the slave byte
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rxb_r <= BYTE_RST;
      rx_empty_r <= 1'b1;
    end else if (m_done) begin
      rxb_r <= m_rx_nxt;
      rx_empty_r <= 1'b0;
    end else if (slave_on && s_done) begin
      rxb_r <= lnk_rx;
      rx_empty_r <= 1'b0;
    end else if (data_rd) begin
      rx_empty_r <= 1'b1;
    end
  end

  // a completion in the clearing cycle keeps the flag set
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      done_r <= 1'b0;
    end else if (m_done || (slave_on && s_done)) begin
      done_r <= 1'b1;
    end else if (done_clr) begin
      done_r <= 1'b0;
    end
  end

  assign mosi_o = sh_r[7];
  assign mosi_oe = master_on;
  assign sck_o = sck_r;
  assign sck_oe = master_on;
  assign miso_o = lnk_miso;
  assign miso_oe = slave_on & selected;
  assign nss_o = mode_r[0];
  assign nss_oe = mode_r[1];
  assign select_routed = (mode_r != MODE_3W);

  assign data_rdata = rxb_r;
  assign master_enable_bit = master_en_r;
  assign port_enable_bit = port_en_r;
  assign select_mode_field = mode_r;
  assign transfer_done_flag = done_r;
  assign write_collision_flag = write_collision_flag_r;
  assign mode_fault_flag = mode_fault_flag_r;
  assign rx_empty = rx_empty_r;
  assign busy = (st_r != SMSSC_IDLE);
endmodule : smssc_core

// ===== hdl/smssc_link.sv
module smssc_link (
  input wire logic sck_link,
  input wire logic nrst,
  input wire logic lnk_clr,
  input wire logic edge_inv,
  input wire logic mosi_i,
  input wire logic [7:0] tx_byte,
  output logic miso_bit,
  output logic [7:0] rx_byte,
  output logic done_tgl,
  output logic ack_tgl
);
  localparam logic [2:0] BIT_LAST_L = 3'h7;
  logic lnk_clk;
  logic [2:0] cnt_r;
  logic [7:0] sh_r;
  logic [7:0] sh_nxt;

  // turns the sampling edge into a rising edge; config is static while enabled
  assign lnk_clk = sck_link ^ edge_inv;
  assign sh_nxt = (cnt_r == 3'h0) ? {tx_byte[6:0], mosi_i} : {sh_r[6:0], mosi_i};
  // before the first edge the shift register logically holds the tx byte
  assign miso_bit = (cnt_r == 3'h0) ? tx_byte[7] : sh_r[7];

  // deselect or disable clears the bit counter; the sck may be stopped then
  always_ff @(posedge lnk_clk or posedge lnk_clr) begin
    if (lnk_clr) begin
      cnt_r <= 3'h0;
      sh_r <= 8'h00;
    end else begin
      cnt_r <= cnt_r + 3'h1;
      sh_r <= sh_nxt;
    end
  end

  always_ff @(posedge lnk_clk or negedge nrst) begin
    if (!nrst) begin
      rx_byte <= 8'h00;
      done_tgl <= 1'b0;
      ack_tgl <= 1'b0;
    end else if (!lnk_clr) begin
      if (cnt_r == BIT_LAST_L) begin
        rx_byte <= sh_nxt;
        done_tgl <= ~done_tgl;
      end
      if (cnt_r == 3'h0) begin
        ack_tgl <= ~ack_tgl;
      end
    end
  end

endmodule : smssc_link

// ===== hdl/smssc_pkg.sv
package smssc_pkg;
  // core clock period and fastest master half bit period
  localparam int CLK_NS = 25;
  localparam int SCK_HALF_NS = 40;
  // least time, so round up to whole core cycles
  localparam int HALF_CYC = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] HALF_LAST = 4'(HALF_CYC - 1);
  localparam int BYTE_BITS = 8;
  localparam logic [4:0] EDGE_LAST = 5'h0F;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [1:0] MODE_3W = 2'h0;
  localparam logic [1:0] MODE_4W_IN = 2'h1;
  localparam logic [1:0] MODE_RST = MODE_4W_IN;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam int SYNC_W = 4;
  localparam int SYNC_MISO = 3;
  localparam int SYNC_SEL = 2;
  localparam int SYNC_DONE = 1;
  localparam int SYNC_ACK = 0;
  typedef enum logic [1:0] {
    SMSSC_IDLE = 2'b00,
    SMSSC_RUN = 2'b01,
    SMSSC_END = 2'b10
  } smssc_mst_t;
endpackage : smssc_pkg

// ===== hdl/smssc_sync.sv
module smssc_sync #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  // first stage is read by the second stage only
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule : smssc_sync

// ===== tb/smssc_checker.sv
module smssc_checker
  import smssc_pkg::*;
(
  input logic core_clk,
  input logic nrst,
  input logic ctrl_wr,
  input logic [1:0] ctrl_mode,
  input logic nss_i,
  input logic clock_polarity_bit,
  input logic master_enable_bit,
  input logic port_enable_bit,
  input logic [1:0] select_mode_field,
  input logic transfer_done_flag,
  input logic mode_fault_flag,
  input logic busy,
  input logic select_routed,
  input logic mosi_oe,
  input logic miso_oe,
  input logic sck_o,
  input logic sck_oe,
  input logic nss_o,
  input logic nss_oe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // toggles per byte; a lost or extra edge corrupts both ends
  logic sck_q_r;
  logic [4:0] tgl_r;
  always_ff @(posedge core_clk) begin
    sck_q_r <= sck_o;
    if (!nrst || !busy) begin
      tgl_r <= 5'h00;
    end else if (sck_o != sck_q_r) begin
      tgl_r <= tgl_r + 5'h01;
    end
  end
  sequence s_fault_cause;
    port_enable_bit && master_enable_bit && select_mode_field == MODE_4W_IN && !nss_i;
  endsequence
  sequence s_fault_done;
    mode_fault_flag && !master_enable_bit && !port_enable_bit;
  endsequence
  AST_FAULT: assert property (s_fault_cause ##1 !nss_i [*2] |-> ##[0:2] s_fault_done)
    else $error("mode fault missing");
  AST_RST: assert property ($rose(nrst) |-> select_mode_field == MODE_RST && !port_enable_bit)
    else $error("reset mode wrong");
  AST_SEL_OUT: assert property (nss_oe == select_mode_field[1] && (!nss_oe || nss_o == select_mode_field[0]))
    else $error("select pin drive wrong");
  AST_ROUTED: assert property (select_routed == (select_mode_field != MODE_3W))
    else $error("routing wrong");
  AST_MST_OE: assert property (mosi_oe == (master_enable_bit && port_enable_bit) && sck_oe == mosi_oe)
    else $error("master drive wrong");
  AST_MISO_OFF: assert property (!port_enable_bit || master_enable_bit |-> !miso_oe)
    else $error("miso driven");
  AST_MISO_3W: assert property (port_enable_bit && !master_enable_bit && select_mode_field == MODE_3W |-> miso_oe)
    else $error("miso not driven");
  AST_SCK_IDLE: assert property (sck_oe && !busy |-> sck_o == clock_polarity_bit)
    else $error("clock not idle");
  AST_DONE: assert property ($fell(busy) |-> ##[0:1] transfer_done_flag)
    else $error("done missing");
  AST_TGL: assert property ($fell(busy) |-> tgl_r == 5'h10)
    else $error("toggle count wrong");
  AST_CTRL: assert property (ctrl_wr && nss_i |=> select_mode_field == $past(ctrl_mode))
    else $error("control not taken");
endmodule : smssc_checker

bind smssc_core smssc_checker u_chk (.*);

// ===== tb/smssc_slv_model.sv
module smssc_slv_model (
  input wire logic sck,
  input wire logic sel,
  input wire logic mosi,
  output logic miso,
  output logic [7:0] rx
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh = 8'hA5;
  // idle low, sample on rising edge only
  always @(posedge sck) if (sel) rx <= {rx[6:0], mosi};
  // rotating so every byte returns the same pattern
  always @(negedge sck) if (sel) sh <= {sh[6:0], sh[7]};
  // released line shows no stale bit
  assign miso = sel ? sh[7] : ~sh[7];
endmodule : smssc_slv_model

// ===== tb/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, nrst, sck_link, ctrl_wr, ctrl_master_en, ctrl_port_en;
  logic [1:0] ctrl_mode, select_mode_field;
  logic clock_polarity_bit, clock_phase_bit, data_wr, data_rd, done_clr, write_collision_flag_clr, mode_fault_flag_clr;
  logic [7:0] data_wdata, data_rdata, prx, q;
  logic master_enable_bit, port_enable_bit, transfer_done_flag, write_collision_flag;
  logic mode_fault_flag, rx_empty, busy, select_routed, mosi_i, mosi_o, mosi_oe;
  logic miso_i, miso_o, miso_oe, sck_o, sck_oe, nss_i, nss_o, nss_oe;
  int miscompares = 0;
  int checked = 0;
  int cyc = 0;
  smssc_core dut (.*);
  // sole slave on the bus
  smssc_slv_model slv (
    .sck(sck_o & sck_oe),
    .sel(nss_oe & ~nss_o),
    .mosi(mosi_o),
    .miso(miso_i),
    .rx(prx)
  );
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task end_sim;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      end_sim;
    end
  end
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task ctl(input logic m, input logic p, input logic [1:0] md);
    @(posedge core_clk) begin
      ctrl_master_en <= m;
      ctrl_port_en <= p;
      ctrl_mode <= md;
      ctrl_wr <= 1'b1;
    end
    @(posedge core_clk) ctrl_wr <= 1'b0;
    @(negedge core_clk);
  endtask : ctl
  task wr(input logic [7:0] d);
    @(posedge core_clk) begin
      data_wdata <= d;
      data_wr <= 1'b1;
    end
    @(posedge core_clk) data_wr <= 1'b0;
  endtask : wr
  task clr;
    @(posedge core_clk) {done_clr, write_collision_flag_clr, mode_fault_flag_clr, data_rd} <= 4'hF;
    @(posedge core_clk) {done_clr, write_collision_flag_clr, mode_fault_flag_clr, data_rd} <= 4'h0;
    @(negedge core_clk);
  endtask : clr
  task wdone;
    int n;
    n = 0;
    while (transfer_done_flag !== 1'b1 && n < 200) begin
      @(negedge core_clk);
      n++;
    end
    chk(8'(transfer_done_flag), 8'h01);
  endtask : wdone
  task t_modes;
    for (int i = 0; i < 4; i++) begin
      ctl(1'b1, 1'b1, 2'(i));
      chk({4'h0, nss_oe, nss_o & nss_oe, select_routed, sck_oe},
          {4'h0, i[1], i[1] & i[0], i != 0, 1'b1});
    end
  endtask : t_modes
  task t_master;
    ctl(1'b1, 1'b1, 2'h2);
    wr(8'h3C);
    wr(8'hC3);
    wr(8'hFF);
    @(negedge core_clk);
    chk(8'(write_collision_flag), 8'h01);
    wdone;
    chk(data_rdata, 8'hA5);
    chk(8'(rx_empty), 8'h00);
    chk(prx, 8'h3C);
    clr;
    chk(8'(rx_empty), 8'h01);
    wdone;
    chk(prx, 8'hC3);
  endtask : t_master
  task t_fault;
    ctl(1'b1, 1'b1, 2'h1);
    @(posedge core_clk) nss_i <= 1'b0;
    repeat (6) @(negedge core_clk);
    chk({5'h00, mode_fault_flag, master_enable_bit, port_enable_bit}, 8'h04);
    @(posedge core_clk) nss_i <= 1'b1;
    repeat (4) @(negedge core_clk);
    clr;
    chk({5'h00, mode_fault_flag, master_enable_bit, port_enable_bit}, 8'h00);
  endtask : t_fault
  // link clock runs only inside frames, idle at polarity
  task frame(input logic [7:0] b, input logic sel);
    nss_i = ~sel;
    #60;
    if (sel) chk(8'({miso_oe, miso_o}), 8'({1'b1, ~b[7]}));
    for (int i = 7; i >= 0; i--) begin
      #8;
      if (!clock_phase_bit) begin
        mosi_i = b[i];
        q[i] = miso_o;
      end
      #8 sck_link = ~sck_link;
      #8;
      if (clock_phase_bit) begin
        mosi_i = b[i];
        q[i] = miso_o;
      end
      #8 sck_link = ~sck_link;
    end
    #30 nss_i = 1'b1;
  endtask : frame
  task t_slave;
    logic [7:0] b;
    logic [1:0] md;
    for (int k = 0; k < 4; k++) begin
      b = 8'h5A ^ 8'(k * 51);
      md = (k == 3) ? 2'h0 : 2'h1;
      ctl(1'b0, 1'b0, md);
      @(posedge core_clk) begin
        clock_polarity_bit <= k[1];
        clock_phase_bit <= k[0];
      end
      sck_link = k[1];
      ctl(1'b0, 1'b1, md);
      chk(8'(miso_oe), 8'(md == 2'h0));
      wr(~b);
      if (md != 2'h0) frame(b, 1'b0);
      repeat (8) @(negedge core_clk);
      chk(8'(transfer_done_flag), 8'h00);
      frame(b, 1'b1);
      wdone;
      chk(data_rdata, b);
      chk(q, ~b);
      clr;
    end
  endtask : t_slave
  initial begin
    {nrst, sck_link, ctrl_wr, ctrl_master_en, ctrl_port_en, ctrl_mode} = '0;
    {clock_polarity_bit, clock_phase_bit, data_wr, data_rd, done_clr, write_collision_flag_clr} = '0;
    {mode_fault_flag_clr, data_wdata, mosi_i} = '0;
    nss_i = 1'b1;
    repeat (16) @(posedge core_clk);
    nrst <= 1'b1;
    @(negedge core_clk);
    chk({master_enable_bit, port_enable_bit, select_mode_field, transfer_done_flag,
         write_collision_flag, mode_fault_flag, nss_oe}, 8'h10);
    t_modes;
    t_master;
    t_fault;
    t_slave;
    ctl(1'b0, 1'b0, 2'h0);
    chk({5'h00, miso_oe, mosi_oe, sck_oe}, 8'h00);
    end_sim;
  end
endmodule : testbench
